/* rcg_regs.svh */
// constants for the remote input command gate
`ifndef RCG_REGS_SVH
`define RCG_REGS_SVH

// number of arms addressable by the 4-bit select
`define RCG_NUM_ARMS 16
// width of the arm and program-set select fields
`define RCG_SEL_W 4
// width of the one-based program-set number
`define RCG_GRP_W 5
// arm index after reset: arm 1 in one-based terms
`define RCG_ARM_RST 4'h0
// program-set select after reset
`define RCG_SET_RST 4'h0
// offset from select value to program-set number
`define RCG_GRP_BASE 5'h01
// number of command and select inputs
`define RCG_IN_W 24
// number of request pulses toward the controller core
`define RCG_REQ_W 14

`endif

/* rcg_pkg.sv */
// types shared by the remote input command gate
package rcg_pkg;

  // discrete remote inputs, msb first
  typedef struct packed {
    logic drive_enable_cmd;
    logic drive_disable_cmd;
    logic full_drive_level_cmd;
    logic reduced_drive_level_cmd;
    logic calibrate_cmd;
    logic origin_cmd;
    logic start_cmd;
    logic suspend_cmd;
    logic resume_cmd;
    logic kill_all_cmd;
    logic reset_cmd;
    logic arm_select_strobe;
    logic prog_set_select_strobe;
    logic restore_cmd;
    logic halt_cmd;
    logic restart_cmd;
    logic arm_sel_bit3;
    logic arm_sel_bit2;
    logic arm_sel_bit1;
    logic arm_sel_bit0;
    logic prog_set_bit3;
    logic prog_set_bit2;
    logic prog_set_bit1;
    logic prog_set_bit0;
  } rcg_in_s;

  // one-cycle requests toward the controller core
  typedef struct packed {
    logic drive_on;
    logic drive_off;
    logic full_level;
    logic reduced_level;
    logic calibrate;
    logic go_origin;
    logic start;
    logic suspend;
    logic resume;
    logic kill_all;
    logic ctrl_reset;
    logic restore;
    logic halt;
    logic restart;
  } rcg_req_s;

endpackage : rcg_pkg

/* rcg_sync_edge.sv */
// two-stage synchroniser with rising-edge detect per input
`timescale 1ns/1ps
`default_nettype none
`include "rcg_regs.svh"
module rcg_sync_edge (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [`RCG_IN_W-1:0] i_raw,
  output logic [`RCG_IN_W-1:0] o_level,
  output logic [`RCG_IN_W-1:0] o_rise
);
  logic [`RCG_IN_W-1:0] meta;
  logic [`RCG_IN_W-1:0] stab;
  logic [`RCG_IN_W-1:0] prev;

  genvar g;
  generate
    for (g = 0; g < `RCG_IN_W; g++) begin : g_bit
      // meta is read only by stab; edge logic looks at stab and prev
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta[g] <= 1'b0;
          stab[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else if (i_ce) begin
          meta[g] <= i_raw[g];
          stab[g] <= meta[g];
          prev[g] <= stab[g];
        end
      end
      assign o_level[g] = stab[g];
      assign o_rise[g] = stab[g] & ~prev[g]; // held level fires once
    end
  endgenerate
endmodule : rcg_sync_edge
`default_nettype wire

/* rcg_arm_table.sv */
// per-arm user drive and power settings
`timescale 1ns/1ps
`default_nettype none
`include "rcg_regs.svh"
module rcg_arm_table (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [`RCG_SEL_W-1:0] i_arm,
  input wire logic i_drive_on,
  input wire logic i_drive_off,
  input wire logic i_full,
  input wire logic i_reduced,
  output logic o_drive_sel,
  output logic o_power_sel
);
  logic drive_set [`RCG_NUM_ARMS];
  logic power_set [`RCG_NUM_ARMS];

  // settings are the user's choice, so only commands change them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < `RCG_NUM_ARMS; k++) begin
        drive_set[k] <= 1'b0;
        power_set[k] <= 1'b0;
      end
    end else if (i_ce) begin
      if (i_drive_on) begin
        drive_set[i_arm] <= 1'b1;
      end else if (i_drive_off) begin
        drive_set[i_arm] <= 1'b0;
      end
      if (i_full) begin
        power_set[i_arm] <= 1'b1;
      end else if (i_reduced) begin
        power_set[i_arm] <= 1'b0;
      end
    end
  end

  // read port follows the selected arm
  assign o_drive_sel = drive_set[i_arm];
  assign o_power_sel = power_set[i_arm];
endmodule : rcg_arm_table
`default_nettype wire

/* rcg_gate.sv */
// remote input command gate: accepts or ignores remote commands
//
// Functional notes
// RULE1: while faulted, ignore every command except reset
// RULE2: reset restarts the controller and clears the fault; accepted always
// RULE3: drive enable only when drive disable low and no tasks run
// RULE4: drive disable switches drives off, blocks enable; not during tasks
// RULE5: full level needs drives on, reduced input low, no tasks
// RULE6: reduced level leaves high power, blocks full; not during tasks
// RULE7: calibrate and go-to-origin only when no tasks run
// RULE8: start launches latched program set; ignored while tasks run
// RULE9: suspend pauses pausable tasks; only while tasks run
// RULE10: resume continues paused tasks; only while tasks run
// RULE11: kill-all aborts tasks or command; only the fault blocks it
// RULE12: arm strobe latches 4-bit zero-based arm number, default zero
// RULE13: latched arm steers drive, calibrate, origin and status outputs
// RULE14: program-set strobe latches 4 bits used by start
// RULE15: program-set number is binary select value plus one, 1 to 16
// RULE16: position restore acts only once the safeguard is closed
// RULE17: controller halt ignored while tasks run
// RULE18: controller restart ignored while tasks run
// RULE19: remote side should watch fault and drive reset itself
// RULE20: command-in-cycle output high while accepted command executes
// RULE21: fault output set on error, held until reset
// RULE22: inputs synchronised; commands act on rising edge only once
`timescale 1ns/1ps
`default_nettype none
`include "rcg_regs.svh"
module rcg_gate (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire rcg_pkg::rcg_in_s i_remote,
  input wire logic i_tasks_running,
  input wire logic i_error_event,
  input wire logic i_cmd_done,
  input wire logic i_safeguard_closed,
  input wire logic [`RCG_NUM_ARMS-1:0] i_cal_done_vec,
  input wire logic [`RCG_NUM_ARMS-1:0] i_at_origin_vec,
  output rcg_pkg::rcg_req_s o_req,
  output logic [`RCG_SEL_W-1:0] o_req_arm,
  output logic [`RCG_GRP_W-1:0] o_start_group,
  output logic [`RCG_SEL_W-1:0] o_current_arm,
  output logic [`RCG_GRP_W-1:0] o_current_group,
  output logic o_drive_setting_flag,
  output logic o_power_setting_flag,
  output logic o_calibration_done_flag,
  output logic o_at_origin_flag,
  output logic o_command_in_cycle_flag,
  output logic o_fault,
  output logic o_restore_pending
);
  import rcg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  // picks a 4-bit select field out of the synchronised level vector
  function automatic logic [`RCG_SEL_W-1:0] sel_field(
    input logic b3,
    input logic b2,
    input logic b1,
    input logic b0
  );
    sel_field = {b3, b2, b1, b0};
  endfunction : sel_field

  logic [`RCG_IN_W-1:0] lvl_vec;
  logic [`RCG_IN_W-1:0] rise_vec;
  rcg_in_s lvl;
  rcg_in_s rise;

  // every remote pin passes two flops before use
  rcg_sync_edge u_sync ( // see RULE22
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_raw(i_remote),
    .o_level(lvl_vec),
    .o_rise(rise_vec)
  );

  assign lvl = rcg_in_s'(lvl_vec);
  assign rise = rcg_in_s'(rise_vec);

  //////////////////////////////////////////////////////////////////////////
  // state registers

  logic fault;
  logic busy;
  logic restore_pend;
  logic [`RCG_SEL_W-1:0] arm;
  logic [`RCG_SEL_W-1:0] prog_set;
  logic drive_sel;
  logic power_sel;

  //////////////////////////////////////////////////////////////////////////
  // acceptance conditions

  logic ok;
  logic free;
  logic idle;
  logic in_tasks;
  rcg_req_s acc;
  logic issue_restore;
  logic any_acc;

  // fault blocks everything but reset
  assign ok = ~fault; // see RULE1
  // a command already in cycle holds off new ones except kill and reset
  assign free = ok & ~busy;
  // most commands are disabled while tasks run
  assign idle = free & ~i_tasks_running;
  // suspend and resume make sense only with tasks running
  assign in_tasks = free & i_tasks_running;

  // drive enable needs the disable level low
  assign acc.drive_on = rise.drive_enable_cmd & idle &
                        ~lvl.drive_disable_cmd; // see RULE3
  // drive disable wins any same-cycle race by holding enable off
  assign acc.drive_off = rise.drive_disable_cmd & idle; // see RULE4
  // full level needs drives on for this arm and reduced level low
  assign acc.full_level = rise.full_drive_level_cmd & idle &
                          drive_sel &
                          ~lvl.reduced_drive_level_cmd; // see RULE5
  assign acc.reduced_level = rise.reduced_drive_level_cmd &
                             idle; // see RULE6
  // motion commands for the selected arm
  assign acc.calibrate = rise.calibrate_cmd & idle; // see RULE7
  assign acc.go_origin = rise.origin_cmd & idle; // see RULE7
  // start uses the latched program set
  assign acc.start = rise.start_cmd & idle; // see RULE8
  assign acc.suspend = rise.suspend_cmd & in_tasks; // see RULE9
  assign acc.resume = rise.resume_cmd & in_tasks; // see RULE10
  // abort must get through a running command, so only fault blocks it
  assign acc.kill_all = rise.kill_all_cmd & ok; // see RULE11
  // reset is honoured in every state
  assign acc.ctrl_reset = rise.reset_cmd; // see RULE2
  // restore is issued from the pending latch, not from the edge
  assign acc.restore = issue_restore; // see RULE16
  assign acc.halt = rise.halt_cmd & idle; // see RULE17
  assign acc.restart = rise.restart_cmd & idle; // see RULE18

  // restore waits until the safeguard is closed and no command is in cycle
  assign issue_restore = restore_pend & i_safeguard_closed &
                         free & ~acc.kill_all &
                         ~acc.ctrl_reset; // see RULE16

  assign any_acc = |acc;

  //////////////////////////////////////////////////////////////////////////
  // per-arm settings

  // table writes use the arm latched before this cycle's strobe
  rcg_arm_table u_arms (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_arm(arm),
    .i_drive_on(acc.drive_on),
    .i_drive_off(acc.drive_off),
    .i_full(acc.full_level),
    .i_reduced(acc.reduced_level),
    .o_drive_sel(drive_sel),
    .o_power_sel(power_sel)
  );

  //////////////////////////////////////////////////////////////////////////
  // fault latch

  // an error in the reset cycle keeps the fault: set beats clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault <= 1'b0;
    end else if (i_ce) begin
      if (i_error_event) begin
        fault <= 1'b1; // see RULE21
      end else if (acc.ctrl_reset) begin
        fault <= 1'b0; // see RULE2
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command-in-cycle tracking

  // a new acceptance in the done cycle keeps the flag set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy <= 1'b0;
    end else if (i_ce) begin
      if (any_acc) begin
        busy <= 1'b1; // see RULE20
      end else if (i_cmd_done) begin
        busy <= 1'b0; // see RULE20
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // restore request latch

  // abort or reset drops a restore that never got its safeguard
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      restore_pend <= 1'b0;
    end else if (i_ce) begin
      if (rise.restore_cmd & free) begin
        restore_pend <= 1'b1; // see RULE16
      end else if (issue_restore | acc.kill_all | acc.ctrl_reset) begin
        restore_pend <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // arm and program-set select latches

  // select bits are sampled only on the strobe edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arm <= `RCG_ARM_RST; // see RULE12
    end else if (i_ce) begin
      if (rise.arm_select_strobe & ok) begin
        arm <= sel_field(lvl.arm_sel_bit3, lvl.arm_sel_bit2,
                         lvl.arm_sel_bit1,
                         lvl.arm_sel_bit0); // see RULE12
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prog_set <= `RCG_SET_RST;
    end else if (i_ce) begin
      if (rise.prog_set_select_strobe & ok) begin
        prog_set <= sel_field(lvl.prog_set_bit3, lvl.prog_set_bit2,
                              lvl.prog_set_bit1,
                              lvl.prog_set_bit0); // see RULE14
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // request outputs

  // one-based program-set number: select value plus one; the extra top
  // bit keeps set sixteen from wrapping back to zero
  function automatic logic [`RCG_GRP_W-1:0] grp_number(
    input logic [`RCG_SEL_W-1:0] sel
  );
    grp_number = {1'b0, sel} + `RCG_GRP_BASE; // see RULE15
  endfunction : grp_number

  logic [`RCG_GRP_W-1:0] next_group;

  // start group and status echo share one decode of the latched set
  assign next_group = grp_number(prog_set); // see RULE15

  // one-cycle pulses; a refused command simply leaves its bit low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req <= '0;
    end else if (i_ce) begin
      o_req <= acc;
    end
  end

  // the arm travels with every pulse, so the core needs no select copy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req_arm <= `RCG_ARM_RST;
    end else if (i_ce) begin
      o_req_arm <= arm; // see RULE13
    end
  end

  // group sampled with the pulse; a later strobe cannot bend a start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_start_group <= `RCG_GRP_BASE;
    end else if (i_ce) begin
      o_start_group <= next_group; // see RULE14
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status outputs

  // selection echo: arm and program set as currently latched
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_current_arm <= `RCG_ARM_RST;
      o_current_group <= `RCG_GRP_BASE;
    end else if (i_ce) begin
      o_current_arm <= arm; // see RULE13
      o_current_group <= next_group; // see RULE15
    end
  end

  // user settings of the selected arm, not what the drives really do
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_drive_setting_flag <= 1'b0;
      o_power_setting_flag <= 1'b0;
    end else if (i_ce) begin
      o_drive_setting_flag <= drive_sel; // see RULE13
      o_power_setting_flag <= power_sel; // see RULE13
    end
  end

  // core status of the selected arm; a new select shows one edge later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_calibration_done_flag <= 1'b0;
      o_at_origin_flag <= 1'b0;
    end else if (i_ce) begin
      o_calibration_done_flag <= i_cal_done_vec[arm]; // see RULE13
      o_at_origin_flag <= i_at_origin_vec[arm]; // see RULE13
    end
  end

  // cycle flag copy; costs an edge of lag but keeps the pin glitch free
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_command_in_cycle_flag <= 1'b0;
    end else if (i_ce) begin
      o_command_in_cycle_flag <= busy; // see RULE20
    end
  end

  // fault copy; the pin stays up through the reset command's own cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault <= 1'b0;
    end else if (i_ce) begin
      o_fault <= fault; // see RULE21
    end
  end

  // restore-pending copy, so the remote side sees a waiting restore
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_restore_pending <= 1'b0;
    end else if (i_ce) begin
      o_restore_pending <= restore_pend; // see RULE16
    end
  end

endmodule : rcg_gate
`default_nettype wire

/* rcg_gate_monitor.sv */
// concurrent checks on the remote command gate ports
`timescale 1ns/1ps
`default_nettype none
`include "rcg_regs.svh"
module rcg_gate_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tasks_running,
  input wire logic i_error_event,
  input wire logic i_cmd_done,
  input wire logic i_safeguard_closed,
  input wire rcg_pkg::rcg_req_s o_req,
  input wire logic [`RCG_GRP_W-1:0] o_current_group,
  input wire logic o_command_in_cycle_flag,
  input wire logic o_fault
);
  import rcg_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // fault pin lags the internal latch by one edge
  sequence s_fault_up;
    ##2 o_fault;
  endsequence
  sequence s_done_seen;
    $past(i_cmd_done, 2);
  endsequence
  ////////////////////////////////////////
  fault_set_a: assert property (i_error_event |-> s_fault_up)
    else $error("fault not raised after error");
  fault_gate_a: assert property (
    o_fault |-> (o_req & 14'h3FF7) == 14'h0000)
    else $error("request issued while faulted");
  fault_clear_a: assert property (
    $fell(o_fault) |-> $past(o_req.ctrl_reset))
    else $error("fault dropped without reset");
  tasks_gate_a: assert property (
    $past(i_tasks_running) |-> (o_req & 14'h3F83) == 14'h0000)
    else $error("command taken while tasks run");
  idle_gate_a: assert property (
    !$past(i_tasks_running) |-> !o_req.suspend && !o_req.resume)
    else $error("pause or resume taken while idle");
  busy_gate_a: assert property (
    o_command_in_cycle_flag |-> (o_req & 14'h3FE7) == 14'h0000)
    else $error("command taken while busy");
  busy_rise_a: assert property (
    |o_req |=> o_command_in_cycle_flag)
    else $error("cycle flag missing after request");
  busy_drop_a: assert property (
    $fell(o_command_in_cycle_flag) |-> s_done_seen)
    else $error("cycle flag dropped early");
  edge_once_a: assert property (
    (o_req & $past(o_req)) == 14'h0000)
    else $error("request longer than one cycle");
  restore_wait_a: assert property (
    o_req.restore |-> $past(i_safeguard_closed))
    else $error("restore with safeguard open");
  group_range_a: assert property (
    o_current_group != 5'h00 && o_current_group <= 5'h10)
    else $error("program set out of range");
endmodule : rcg_gate_monitor

bind rcg_gate rcg_gate_monitor u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_tasks_running(i_tasks_running),
  .i_error_event(i_error_event), .i_cmd_done(i_cmd_done),
  .i_safeguard_closed(i_safeguard_closed), .o_req(o_req),
  .o_current_group(o_current_group),
  .o_command_in_cycle_flag(o_command_in_cycle_flag), .o_fault(o_fault)
);
`default_nettype wire

/* rcg_core_model.sv */
// controller core stand-in: completes commands and tracks tasks
`timescale 1ns/1ps
`default_nettype none
module rcg_core_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire rcg_pkg::rcg_req_s i_req,
  input wire logic i_busy,
  output logic o_cmd_done,
  output logic o_tasks_running
);
  import rcg_pkg::*;
  logic [3:0] wait_cnt;
  // finish the command in cycle, promptly or after a long stall
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt <= 4'h0;
      o_cmd_done <= 1'b0;
    end else begin
      o_cmd_done <= 1'b0;
      if (!i_busy) begin
        wait_cnt <= 4'h0;
      end else if (!o_cmd_done) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == (i_slow ? 4'h9 : 4'h1)) begin
          o_cmd_done <= 1'b1;
          wait_cnt <= 4'h0;
        end
      end
    end
  end
  // start launches tasks; kill-all or a controller reset ends them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_tasks_running <= 1'b0;
    else if (i_req.kill_all || i_req.ctrl_reset) o_tasks_running <= 1'b0;
    else if (i_req.start) o_tasks_running <= 1'b1;
  end
endmodule : rcg_core_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the remote command gate
`timescale 1ns/1ps
`default_nettype none
`include "rcg_regs.svh"
module tb_top;
  import rcg_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [23:0] pins = 24'h000000;
  logic err_ev = 1'b0;
  logic safe = 1'b1;
  logic slow = 1'b0;
  logic [15:0] cal_vec = 16'h0000;
  logic done, tasks, drv_flag, pwr_flag, cal_flag, org_flag, busy, fault, pend;
  rcg_req_s req;
  logic [3:0] req_arm, cur_arm;
  logic [3:0] ea = 4'h0;
  logic [4:0] start_grp, cur_grp, eg = 5'h01;
  logic [22:0] seen;
  logic [22:0] notes[$];
  int blk[9] = '{23, 22, 21, 20, 19, 18, 17, 9, 8};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int rs;
  rcg_gate u_rcg_gate (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_remote(pins), .i_tasks_running(tasks), .i_error_event(err_ev),
    .i_cmd_done(done), .i_safeguard_closed(safe), .i_cal_done_vec(cal_vec),
    .i_at_origin_vec(~cal_vec), .o_req(req), .o_req_arm(req_arm),
    .o_start_group(start_grp), .o_current_arm(cur_arm),
    .o_current_group(cur_grp), .o_drive_setting_flag(drv_flag),
    .o_power_setting_flag(pwr_flag), .o_calibration_done_flag(cal_flag),
    .o_at_origin_flag(org_flag), .o_command_in_cycle_flag(busy),
    .o_fault(fault), .o_restore_pending(pend));
  rcg_core_model u_rcg_core_model (.i_clk(i_clk), .i_rst(i_rst),
    .i_slow(slow), .i_req(req), .i_busy(busy), .o_cmd_done(done),
    .o_tasks_running(tasks));
  always #2.5 i_clk = ~i_clk;
  ////////////////////////////////////////
  task automatic check(input logic [22:0] got, input logic [22:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // bounded wait for the cycle flag; a stuck flag is a failure
  task automatic settle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      tick(1);
      k++;
    end
    check(busy, 1'b0);
    tick(2);
  endtask : settle
  // raise one pin, note the request it should give, then drop it unless keep is set
  task automatic fire(input int p, input bit acc, input bit keep);
    logic [13:0] r;
    r = 14'h0000;
    if (p >= 14) r[p-10] = 1'b1;
    else if (p == 13) r[3] = 1'b1;
    else if (p >= 8 && p <= 10) r[p-8] = 1'b1;
    if (acc) notes.push_back({r, ea, r[7] ? eg : 5'h00});
    pins[p] = 1'b1;
    tick(3);
    if (!keep) pins[p] = 1'b0;
    tick(4);
    settle();
  endtask : fire
  // select bits settle well before the strobe rises
  task automatic pick(input int s, input logic [3:0] v);
    if (s == 12) pins[7:4] = v;
    else pins[3:0] = v;
    tick(4);
    fire(s, 1'b0, 1'b0);
  endtask : pick
  // every request pulse is matched against the oldest note
  always @(negedge i_clk) begin
    if (!i_rst && req !== 14'h0000) begin
      seen = {req, req_arm, req.start ? start_grp : 5'h00};
      if (notes.size() == 0) check(seen, 23'h7FFFFF);
      else check(seen, notes.pop_front());
    end
  end
  // a hang is cut short and counted
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial begin
    rs = $urandom(35);
    tick(10);
    i_rst = 1'b0;
    tick(2);
    check(cur_grp, 5'h01);
    check(cur_arm, 4'h0);
    for (int g = 0; g < 16; g++) begin
      pick(11, g[3:0]);
      eg = 5'(g + 1);
      check(cur_grp, eg);
    end
    ea = 4'($urandom_range(15));
    cal_vec = 16'($urandom);
    pick(12, ea);
    check(cur_arm, ea);
    check(cal_flag, cal_vec[ea]);
    check(org_flag, !cal_vec[ea]);
    $display("test selects done");
    fire(22, 1'b1, 1'b1);
    fire(23, 1'b0, 1'b0);
    pins[22] = 1'b0;
    fire(23, 1'b1, 1'b0);
    check(drv_flag, 1'b1);
    fire(20, 1'b1, 1'b1);
    fire(21, 1'b0, 1'b0);
    pins[20] = 1'b0;
    fire(21, 1'b1, 1'b0);
    check(pwr_flag, 1'b1);
    fire(20, 1'b1, 1'b0);
    check(pwr_flag, 1'b0);
    fire(22, 1'b1, 1'b0);
    check(drv_flag, 1'b0);
    fire(21, 1'b0, 1'b0);
    fire(19, 1'b1, 1'b1);
    tick(20);
    pins[19] = 1'b0;
    fire(18, 1'b1, 1'b0);
    fire(9, 1'b1, 1'b0);
    fire(8, 1'b1, 1'b0);
    $display("test idle commands done");
    slow = 1'b1;
    fire(17, 1'b1, 1'b0);
    check(tasks, 1'b1);
    foreach (blk[i]) fire(blk[i], 1'b0, 1'b0);
    fire(16, 1'b1, 1'b0);
    fire(15, 1'b1, 1'b0);
    fire(14, 1'b1, 1'b0);
    check(tasks, 1'b0);
    fire(16, 1'b0, 1'b0);
    fire(15, 1'b0, 1'b0);
    slow = 1'b0;
    $display("test task commands done");
    safe = 1'b0;
    fire(10, 1'b0, 1'b0);
    check(pend, 1'b1);
    notes.push_back({14'h0004, ea, 5'h00});
    safe = 1'b1;
    tick(4);
    settle();
    check(pend, 1'b0);
    $display("test restore done");
    err_ev = 1'b1;
    tick(1);
    err_ev = 1'b0;
    tick(3);
    check(fault, 1'b1);
    fire(9, 1'b0, 1'b0);
    fire(14, 1'b0, 1'b0);
    pick(12, ~ea);
    check(cur_arm, ea);
    // the remote side watches the fault and clears it itself
    if (fault === 1'b1) fire(13, 1'b1, 1'b0);
    check(fault, 1'b0);
    $display("test fault done");
    tick(10);
    check(23'(notes.size()), 23'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
